/* File: hw/pdm_fifo.v */
// synchronous fifo with valid/ready on both sides
// assumes one clock; full and empty derive from a stored occupancy count
`timescale 1ns/1ns
module pdm_fifo #(
	parameter W  = 20,
	parameter D  = 8,
	parameter AW = 3
) (
	input  wire          mclk,
	input  wire          rst,
	input  wire          ce,
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	output wire          out_valid,
	input  wire          out_ready,
	output reg  [W-1:0]  out_data,
	output reg  [AW:0]   level
);
	reg  [W-1:0]  mem [0:D-1];
	reg  [AW-1:0] wr_ptr_reg;
	reg  [AW-1:0] rd_ptr_reg;
	wire          push;
	wire          pop;

	assign in_ready  = (level != D[AW:0]);
	assign out_valid = (level != {(AW+1){1'b0}});
	assign push      = ce & in_valid & in_ready;
	assign pop       = ce & out_valid & out_ready;

	always @* begin
		out_data = mem[rd_ptr_reg];
	end

	always @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			level      <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				level <= level + 1'b1;
			end else if (pop & ~push) begin
				level <= level - 1'b1;
			end
		end
	end
endmodule

/* File: hw/pdm_sig_decode.v */
// decodes a setpoint signal id into internal code, width and mode class
// assumes pure combinational use by the mapper
`timescale 1ns/1ns
`include "pdm_consts.vh"
module pdm_sig_decode (
	input  wire [15:0] sig_id,
	output reg  [4:0]  sig_code,
	output reg         sig_is32,
	output reg  [1:0]  sig_mode
);
	always @* begin
		sig_code = {1'b0, `PDM_SIG_NONE};
		sig_is32 = 1'b0;
		sig_mode = `PDM_MODE_ANY;
		case (sig_id)
		`PDM_ID_CTRL1: begin
			sig_code = {1'b0, `PDM_SIG_CTRL1};
		end
		`PDM_ID_SPEED16: begin
			sig_code = {1'b0, `PDM_SIG_SPEED16};
			sig_mode = `PDM_MODE_SPEED;
		end
		`PDM_ID_SPEED32: begin
			sig_code = {1'b0, `PDM_SIG_SPEED32};
			sig_is32 = 1'b1;
			sig_mode = `PDM_MODE_SPEED;
		end
		`PDM_ID_ENC1_CW: begin
			sig_code = {1'b0, `PDM_SIG_ENC1_CW};
			sig_mode = `PDM_MODE_SPEED;
		end
		`PDM_ID_ENC2_CW: begin
			sig_code = {1'b0, `PDM_SIG_ENC2_CW};
			sig_mode = `PDM_MODE_SPEED;
		end
		`PDM_ID_DEVIATION, `PDM_ID_GAIN: begin
			sig_code = (sig_id == `PDM_ID_GAIN) ? {1'b0, `PDM_SIG_GAIN} :
				{1'b0, `PDM_SIG_DEVIATION};
			sig_is32 = 1'b1;
			sig_mode = `PDM_MODE_SPEED;
		end
		`PDM_ID_EXT_TORQUE: begin
			sig_code = {1'b0, `PDM_SIG_EXT_TORQ};
		end
		`PDM_ID_XLINK_CW: begin
			sig_code = {1'b0, `PDM_SIG_XLINK_CW};
			sig_mode = `PDM_MODE_POS;
		end
		`PDM_ID_EXT_POS, `PDM_ID_EXT_CORR: begin
			sig_code = (sig_id == `PDM_ID_EXT_POS) ? {1'b0, `PDM_SIG_EXT_POS} :
				{1'b0, `PDM_SIG_EXT_CORR};
			sig_is32 = 1'b1;
			sig_mode = `PDM_MODE_POS;
		end
		`PDM_ID_DI_POS, `PDM_ID_DI_VEL: begin
			sig_code = (sig_id == `PDM_ID_DI_POS) ? {1'b0, `PDM_SIG_DI_POS} :
				{1'b0, `PDM_SIG_DI_VEL};
			sig_is32 = 1'b1;
			sig_mode = `PDM_MODE_POS;
		end
		`PDM_ID_DI_ACC, `PDM_ID_DI_DEC, `PDM_ID_DI_MODE: begin
			sig_code = (sig_id == `PDM_ID_DI_ACC) ? {1'b0, `PDM_SIG_DI_ACC} :
				(sig_id == `PDM_ID_DI_DEC) ? {1'b0, `PDM_SIG_DI_DEC} :
				`PDM_SIG_DI_MODE;
			sig_mode = `PDM_MODE_POS;
		end
		default: begin
			sig_code = {1'b0, `PDM_SIG_NONE};
		end
		endcase
	end
endmodule

/* File: hw/pdm_slot_mapper.v */
// maps received setpoint process-data words onto internal drive signals
// assumes words arrive from same-clock fieldbus logic, one slot index each,
// slot 0 being the first word of the telegram; software uses Avalon-MM
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "pdm_consts.vh"
module pdm_slot_mapper #(
	parameter FIFO_DEPTH = `PDM_FIFO_DEPTH,
	parameter FIFO_AW    = 3
) (
	input  wire        mclk,
	input  wire        rst,
	input  wire        ce,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire        rx_valid,
	output wire        rx_ready,
	input  wire [3:0]  rx_slot,
	input  wire [15:0] rx_word,
	input  wire [15:0] enc2_status_word,
	input  wire [31:0] enc2_position_value1,
	input  wire [31:0] enc2_position_value2,
	output wire        enc2_active,
	output wire        positioning_mode,
	output wire [15:0] encoder_config_word,
	output reg         sig_update,
	output reg  [4:0]  sig_code,
	output wire [15:0] control_word1,
	output wire [15:0] speed_setpoint16,
	output wire [31:0] speed_setpoint32,
	output wire [15:0] enc1_control_word,
	output wire [15:0] enc2_control_word,
	output wire [31:0] system_deviation,
	output wire [31:0] position_gain_factor,
	output wire [15:0] external_torque_setpoint,
	output wire [15:0] crosslink_control_word,
	output wire [31:0] external_position_reference,
	output wire [31:0] external_position_correction,
	output wire [31:0] direct_target_position,
	output wire [31:0] direct_target_velocity,
	output wire [15:0] direct_accel_override,
	output wire [15:0] direct_decel_override,
	output wire [15:0] direct_input_mode
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg  [15:0]        telegram_selector_reg;
	reg  [15:0]        drive_config_word_reg = 16'h0000;
	reg  [15:0]        encoder_config_word_reg;
	reg  [2:0]         ctrl_reg;
	reg  [15:0]        setpoint_slot_map [0:`PDM_MAP_ENTRIES-1];
	reg                enc2_active_reg;
	reg                boot_reg;
	reg                ack_reg;
	reg  [31:0]        sig_reg [1:`PDM_SIG_COUNT-1];
	reg                hold_valid_reg;
	reg  [3:0]         hold_slot_reg;
	reg  [4:0]         hold_code_reg;
	reg  [15:0]        hold_word_reg;
	reg  [31:0]        rd_next;
	reg  [15:0]        eff_id;
	wire               req;
	wire               wr_take;
	wire               map_hit;
	wire [4:0]         map_idx;
	wire               f_valid;
	wire               f_ready;
	wire [19:0]        f_data;
	wire [FIFO_AW:0]   f_level;
	wire [3:0]         f_slot;
	wire [15:0]        f_word;
	wire [4:0]         dec_code;
	wire               dec_is32;
	wire [1:0]         dec_mode;
	wire               mode_ok;
	wire               apply;
	wire               pair_ok;
	integer            i;
	integer            j;

	assign req      = avs_read | avs_write;
	assign avs_waitrequest = req & ~(ack_reg & ce);
	assign wr_take  = ce & avs_write & ack_reg;
	assign map_hit  = avs_address[7] & (avs_address[6:2] < `PDM_MAP_ENTRIES);
	assign map_idx  = avs_address[6:2];

	// ----------------------------------------------------------------
	// avalon slave: one wait cycle, then the access completes
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else if (ce) begin
			ack_reg <= req & ~ack_reg;
		end
	end

	always @* begin
		rd_next = 32'h00000000;
		if (map_hit) begin
			rd_next = {16'h0000, setpoint_slot_map[map_idx]};
		end else begin
			case (avs_address)
			`PDM_OFS_TELEGRAM: rd_next = {16'h0000, telegram_selector_reg};
			`PDM_OFS_DRV_CFG:  rd_next = {16'h0000, drive_config_word_reg};
			`PDM_OFS_ENC_CFG:  rd_next = {16'h0000, encoder_config_word_reg};
			`PDM_OFS_CTRL:     rd_next = {29'h00000000, ctrl_reg};
			`PDM_OFS_STATUS:   rd_next = {23'h000000, f_level, 4'h0, enc2_active_reg};
			`PDM_OFS_E2_STAT:  rd_next = enc2_active_reg ?
				{16'h0000, enc2_status_word} : 32'h00000000;
			`PDM_OFS_E2_POS1:  rd_next = enc2_active_reg ?
				enc2_position_value1 : 32'h00000000;
			`PDM_OFS_E2_POS2:  rd_next = enc2_active_reg ?
				enc2_position_value2 : 32'h00000000;
			default:           rd_next = 32'h00000000;
			endcase
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (ce & avs_read & ~ack_reg) begin
			avs_readdata <= rd_next;
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			telegram_selector_reg   <= `PDM_TEL_FREE;
			encoder_config_word_reg <= 16'h0000;
			ctrl_reg                <= `PDM_CTRL_RST;
			for (i = 0; i < `PDM_MAP_ENTRIES; i = i + 1) begin
				setpoint_slot_map[i] <= `PDM_ID_NONE;
			end
		end else if (wr_take) begin
			if (map_hit) begin
				setpoint_slot_map[map_idx] <= avs_writedata[15:0];
			end else begin
				case (avs_address)
				`PDM_OFS_TELEGRAM: telegram_selector_reg   <= avs_writedata[15:0];
				`PDM_OFS_ENC_CFG:  encoder_config_word_reg <= avs_writedata[15:0];
				`PDM_OFS_CTRL:     ctrl_reg                <= avs_writedata[2:0];
				default: begin
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// drive config survives reset; encoder 2 enable is caught at boot
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (wr_take & ~map_hit & (avs_address == `PDM_OFS_DRV_CFG)) begin
			drive_config_word_reg <= avs_writedata[15:0];
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			boot_reg        <= 1'b1;
			enc2_active_reg <= 1'b0;
		end else if (ce & boot_reg) begin
			boot_reg        <= 1'b0;
			enc2_active_reg <= drive_config_word_reg[`PDM_DRV_ENC2_BIT];
		end
	end

	assign enc2_active         = enc2_active_reg;
	assign positioning_mode    = ctrl_reg[`PDM_CTRL_POS_BIT];
	assign encoder_config_word = encoder_config_word_reg;

	// ----------------------------------------------------------------
	// word buffer between fieldbus and mapper
	// ----------------------------------------------------------------
	pdm_fifo #(
		.W  (20),
		.D  (FIFO_DEPTH),
		.AW (FIFO_AW)
	) u_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.ce        (ce),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   ({rx_slot, rx_word}),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data),
		.level     (f_level)
	);

	assign f_slot  = f_data[19:16];
	assign f_word  = f_data[15:0];
	assign f_ready = ~ctrl_reg[`PDM_CTRL_HOLD_BIT];

	// ----------------------------------------------------------------
	// effective signal id of the slot being drained
	// ----------------------------------------------------------------
	always @* begin
		eff_id = `PDM_ID_NONE;
		case (telegram_selector_reg)
		`PDM_TEL_FREE: begin
			if (ctrl_reg[`PDM_CTRL_NEW_BIT]) begin
				if (f_slot < `PDM_FIXED_NEW) begin
					eff_id = `PDM_ID_CTRL1;
				end else begin
					eff_id = setpoint_slot_map[{1'b0, f_slot} + 5'h01];
				end
			end else begin
				case (f_slot)
				4'h0: eff_id = `PDM_ID_CTRL1;
				4'h1: eff_id = `PDM_ID_SPEED16;
				4'h2: eff_id = `PDM_ID_ENC1_CW;
				4'h3: eff_id = `PDM_ID_ENC2_CW;
				default: eff_id = setpoint_slot_map[{1'b0, f_slot} + 5'h01];
				endcase
			end
		end
		`PDM_TEL_SPEED: begin
			case (f_slot)
			4'h0: eff_id = `PDM_ID_CTRL1;
			4'h1: eff_id = `PDM_ID_SPEED16;
			default: eff_id = `PDM_ID_NONE;
			endcase
		end
		`PDM_TEL_POS: begin
			case (f_slot)
			4'h0: eff_id = `PDM_ID_CTRL1;
			4'h1: eff_id = ctrl_reg[`PDM_CTRL_POS_BIT] ? `PDM_ID_XLINK_CW : `PDM_ID_SPEED16;
			default: eff_id = `PDM_ID_NONE;
			endcase
		end
		default: begin
			eff_id = `PDM_ID_NONE;
		end
		endcase
	end

	pdm_sig_decode u_decode (
		.sig_id   (eff_id),
		.sig_code (dec_code),
		.sig_is32 (dec_is32),
		.sig_mode (dec_mode)
	);

	assign mode_ok = (dec_mode == `PDM_MODE_ANY) |
		((dec_mode == `PDM_MODE_POS) == ctrl_reg[`PDM_CTRL_POS_BIT]);
	assign apply   = ce & f_valid & f_ready & (dec_code != {1'b0, `PDM_SIG_NONE}) & mode_ok &
		((dec_code != {1'b0, `PDM_SIG_ENC2_CW}) | enc2_active_reg);
	assign pair_ok = hold_valid_reg & (hold_code_reg == dec_code) &
		(hold_slot_reg + 4'h1 == f_slot);

	// ----------------------------------------------------------------
	// mapping: 16-bit words land at once, 32-bit pairs high word first
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (rst) begin
			hold_valid_reg <= 1'b0;
			hold_slot_reg  <= 4'h0;
			hold_code_reg  <= 5'h00;
			hold_word_reg  <= 16'h0000;
			sig_update     <= 1'b0;
			sig_code       <= 5'h00;
			for (j = 1; j < `PDM_SIG_COUNT; j = j + 1) begin
				sig_reg[j] <= 32'h00000000;
			end
		end else if (ce) begin
			sig_update <= 1'b0;
			if (f_valid & f_ready) begin
				hold_valid_reg <= 1'b0;
				if (apply & dec_is32 & ~pair_ok) begin
					hold_valid_reg <= 1'b1;
					hold_slot_reg  <= f_slot;
					hold_code_reg  <= dec_code;
					hold_word_reg  <= f_word;
				end else if (apply & dec_is32) begin
					sig_reg[dec_code] <= {hold_word_reg, f_word};
					sig_update        <= 1'b1;
					sig_code          <= dec_code;
				end else if (apply) begin
					sig_reg[dec_code] <= {16'h0000, f_word};
					sig_update        <= 1'b1;
					sig_code          <= dec_code;
				end
			end
		end
	end

	assign control_word1                = sig_reg[`PDM_SIG_CTRL1][15:0];
	assign speed_setpoint16             = sig_reg[`PDM_SIG_SPEED16][15:0];
	assign speed_setpoint32             = sig_reg[`PDM_SIG_SPEED32];
	assign enc1_control_word            = sig_reg[`PDM_SIG_ENC1_CW][15:0];
	assign enc2_control_word            = sig_reg[`PDM_SIG_ENC2_CW][15:0];
	assign system_deviation             = sig_reg[`PDM_SIG_DEVIATION];
	assign position_gain_factor         = sig_reg[`PDM_SIG_GAIN];
	assign external_torque_setpoint     = sig_reg[`PDM_SIG_EXT_TORQ][15:0];
	assign crosslink_control_word       = sig_reg[`PDM_SIG_XLINK_CW][15:0];
	assign external_position_reference  = sig_reg[`PDM_SIG_EXT_POS];
	assign external_position_correction = sig_reg[`PDM_SIG_EXT_CORR];
	assign direct_target_position       = sig_reg[`PDM_SIG_DI_POS];
	assign direct_target_velocity       = sig_reg[`PDM_SIG_DI_VEL];
	assign direct_accel_override        = sig_reg[`PDM_SIG_DI_ACC][15:0];
	assign direct_decel_override        = sig_reg[`PDM_SIG_DI_DEC][15:0];
	assign direct_input_mode            = sig_reg[`PDM_SIG_DI_MODE][15:0];
endmodule

/* File: inc/pdm_consts.vh */
// constants of the process-data slot mapper: register map, signal ids, codes
// assumes inclusion by bare name from every design file of the block but the fifo
//
// Overview of operation
// - second encoder takes one control word, returns status word and two positions
// - drive config bit 12 enables encoder 2, taking effect after next reset
// - selector above zero picks a fixed layout: 1 speed, 101 positioning; any other nonzero value maps no word
// - selector zero means free layout driven by the slot map
// - older behaviour: words 1 to 4 fixed, words 5 to 16 mapped
// - newer behaviour: word 1 fixed, words 2 to 16 mapped
// - slot map holds a 16-bit id per slot, reset zero, effective at once
// - ids 50005 and 50007 are 16 and 32-bit speed setpoints
// - ids 50009 and 50013 are encoder 1 and encoder 2 control words
// - ids 50025 and 50026 are 32-bit deviation and gain factor
// - ids 50113 and 50117 are torque setpoint and crosslink control word
// - ids 50207 and 50209 are position reference and correction, positioning only
// - ids 50221 to 50229 are direct-input position, velocity, overrides, mode
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PDM_OFS_TELEGRAM  8'h00
`define PDM_OFS_DRV_CFG   8'h04
`define PDM_OFS_ENC_CFG   8'h08
`define PDM_OFS_CTRL      8'h0C
`define PDM_OFS_STATUS    8'h10
`define PDM_OFS_E2_STAT   8'h14
`define PDM_OFS_E2_POS1   8'h18
`define PDM_OFS_E2_POS2   8'h1C
`define PDM_OFS_MAP_BASE  8'h80
`define PDM_MAP_ENTRIES   17
`define PDM_DRV_ENC2_BIT  12
`define PDM_CTRL_POS_BIT  0
`define PDM_CTRL_NEW_BIT  1
`define PDM_CTRL_HOLD_BIT 2
`define PDM_CTRL_RST      3'h2
// ----------------------------------------------------------------
// telegram selector values and fixed slot counts
// ----------------------------------------------------------------
`define PDM_TEL_FREE      16'h0000
`define PDM_TEL_SPEED     16'h0001
`define PDM_TEL_POS       16'h0065
`define PDM_FIXED_OLD     4'h4
`define PDM_FIXED_NEW     4'h1
// ----------------------------------------------------------------
// signal ids
// ----------------------------------------------------------------
`define PDM_ID_NONE       16'h0000
`define PDM_ID_CTRL1      16'hC351
`define PDM_ID_SPEED16    16'hC355
`define PDM_ID_SPEED32    16'hC357
`define PDM_ID_ENC1_CW    16'hC359
`define PDM_ID_ENC2_CW    16'hC35D
`define PDM_ID_DEVIATION  16'hC369
`define PDM_ID_GAIN       16'hC36A
`define PDM_ID_EXT_TORQUE 16'hC3C1
`define PDM_ID_XLINK_CW   16'hC3C5
`define PDM_ID_EXT_POS    16'hC41F
`define PDM_ID_EXT_CORR   16'hC421
`define PDM_ID_DI_POS     16'hC42D
`define PDM_ID_DI_VEL     16'hC42F
`define PDM_ID_DI_ACC     16'hC431
`define PDM_ID_DI_DEC     16'hC433
`define PDM_ID_DI_MODE    16'hC435
// ----------------------------------------------------------------
// internal signal codes and operating-mode classes
// ----------------------------------------------------------------
`define PDM_SIG_W         4
`define PDM_SIG_NONE      4'h0
`define PDM_SIG_CTRL1     4'h1
`define PDM_SIG_SPEED16   4'h2
`define PDM_SIG_SPEED32   4'h3
`define PDM_SIG_ENC1_CW   4'h4
`define PDM_SIG_ENC2_CW   4'h5
`define PDM_SIG_DEVIATION 4'h6
`define PDM_SIG_GAIN      4'h7
`define PDM_SIG_EXT_TORQ  4'h8
`define PDM_SIG_XLINK_CW  4'h9
`define PDM_SIG_EXT_POS   4'hA
`define PDM_SIG_EXT_CORR  4'hB
`define PDM_SIG_DI_POS    4'hC
`define PDM_SIG_DI_VEL    4'hD
`define PDM_SIG_DI_ACC    4'hE
`define PDM_SIG_DI_DEC    4'hF
`define PDM_SIG_COUNT     17
`define PDM_SIG_DI_MODE   5'h10
`define PDM_MODE_ANY      2'h0
`define PDM_MODE_SPEED    2'h1
`define PDM_MODE_POS      2'h2
`define PDM_FIFO_DEPTH    8
`endif

/* File: tb/pdm_fb_master.sv */
// partner model: fieldbus master handing setpoint words to the mapper
// assumes rx_ready is sampled at rising edges of mclk
`timescale 1ns/1ns
module pdm_fb_master (
	input  wire logic   mclk,
	input  wire logic   rx_ready,
	output logic        rx_valid,
	output logic [3:0]  rx_slot,
	output logic [15:0] rx_word
);
	// ------------------------------
	// word transfer
	// ------------------------------
	initial begin
		rx_valid = 1'b0;
		rx_slot  = 4'h0;
		rx_word  = 16'hFFFF;
	end
	// idle lines show the inverse so stale data never looks current
	task automatic send(input logic [3:0] s, input logic [15:0] w, input int gap);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_slot  <= s;
		rx_word  <= w;
		do
			@(posedge mclk);
		while (rx_ready !== 1'b1);
		rx_valid <= 1'b0;
		rx_slot  <= ~s;
		rx_word  <= ~w;
	endtask
endmodule

/* File: tb/pdm_slot_mapper_monitor.sv */
// checker: bus, stream and signal-hold relations at the mapper's ports
// assumes one clock, synchronous active-high reset, bound to pdm_slot_mapper
`timescale 1ns/1ns
module pdm_slot_mapper_monitor (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        rx_ready,
	input wire logic        enc2_active,
	input wire logic        positioning_mode,
	input wire logic        sig_update,
	input wire logic [4:0]  sig_code,
	input wire logic [15:0] speed_setpoint16,
	input wire logic [31:0] direct_target_position
);
	// ------------------------------
	// properties
	// ------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_req_start;
		$rose(avs_read || avs_write);
	endsequence
	sequence s_waiting;
		(avs_read || avs_write) && avs_waitrequest && ce;
	endsequence
	a_first_waits: assert property (s_req_start |-> avs_waitrequest)
		else $error("request answered without a wait cycle");
	a_one_wait: assert property (s_waiting |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_reset_clean: assert property (
		$fell(rst) |-> !sig_update && rx_ready && !positioning_mode)
		else $error("outputs not clean after reset");
	a_enc2_steady: assert property (
		!$past(rst) && !$past(rst, 2) |-> $stable(enc2_active))
		else $error("encoder 2 enable changed outside reset");
	a_enc2_gate: assert property (sig_update && !enc2_active |-> sig_code != 5'h05)
		else $error("encoder 2 word applied while inactive");
	a_code_valid: assert property (sig_update |-> sig_code != 5'h00 && sig_code <= 5'h10)
		else $error("update with invalid signal code");
	a_speed_hold: assert property (
		!(sig_update && sig_code == 5'h02) |-> $stable(speed_setpoint16))
		else $error("speed setpoint changed without its update");
	a_pos_hold: assert property (
		!(sig_update && sig_code == 5'h0C) |-> $stable(direct_target_position))
		else $error("target position changed without its update");
	a_mode_gate: assert property (
		sig_update && !$past(positioning_mode) |-> sig_code < 5'h09)
		else $error("positioning signal applied in speed mode");
endmodule

bind pdm_slot_mapper pdm_slot_mapper_monitor mon_u (.*);

/* File: tb/pdm_slot_mapper_tb.sv */
// testbench: registers, signal ids, fixed layouts and buffering of the mapper
// assumes the partner model and checker files are compiled before it
`timescale 1ns/1ns
`include "pdm_consts.vh"
module pdm_slot_mapper_tb;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [15:0] enc2_status_word = 16'h0;
	logic [31:0] enc2_position_value1 = 32'h0;
	logic [31:0] enc2_position_value2 = 32'h0;
	wire         avs_waitrequest, rx_valid, rx_ready, enc2_active, positioning_mode, sig_update;
	wire  [3:0]  rx_slot;
	wire  [4:0]  sig_code;
	wire  [15:0] rx_word, encoder_config_word, control_word1, speed_setpoint16;
	wire  [15:0] enc1_control_word, enc2_control_word, external_torque_setpoint;
	wire  [15:0] crosslink_control_word, direct_accel_override, direct_decel_override;
	wire  [15:0] direct_input_mode;
	wire  [31:0] avs_readdata, speed_setpoint32, system_deviation, position_gain_factor;
	wire  [31:0] external_position_reference, external_position_correction;
	wire  [31:0] direct_target_position, direct_target_velocity;
	integer      seed = 32'hD982;
	int          fails = 0;
	int          comparisons = 0;
	int          cycles = 0;
	logic [36:0] exp_q[$];
	logic [31:0] rd_q;
	localparam logic [15:0] IDS [15] = '{`PDM_ID_SPEED16, `PDM_ID_SPEED32, `PDM_ID_ENC1_CW,
		`PDM_ID_ENC2_CW, `PDM_ID_DEVIATION, `PDM_ID_GAIN, `PDM_ID_EXT_TORQUE, `PDM_ID_XLINK_CW,
		`PDM_ID_EXT_POS, `PDM_ID_EXT_CORR, `PDM_ID_DI_POS, `PDM_ID_DI_VEL, `PDM_ID_DI_ACC,
		`PDM_ID_DI_DEC, `PDM_ID_DI_MODE};
	localparam logic [14:0] W32 = 15'h0F32;
	localparam logic [14:0] POS = 15'h7F80;

	pdm_slot_mapper dut_u (.*);
	pdm_fb_master fb_u (.*);

	// ------------------------------
	// clock, timeout, scoreboard
	// ------------------------------
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			close_out;
		end
	end
	function logic [31:0] sig_val(input logic [4:0] c);
		case (c)
			5'h01: sig_val = {16'h0, control_word1};
			5'h02: sig_val = {16'h0, speed_setpoint16};
			5'h03: sig_val = speed_setpoint32;
			5'h04: sig_val = {16'h0, enc1_control_word};
			5'h05: sig_val = {16'h0, enc2_control_word};
			5'h06: sig_val = system_deviation;
			5'h07: sig_val = position_gain_factor;
			5'h08: sig_val = {16'h0, external_torque_setpoint};
			5'h09: sig_val = {16'h0, crosslink_control_word};
			5'h0A: sig_val = external_position_reference;
			5'h0B: sig_val = external_position_correction;
			5'h0C: sig_val = direct_target_position;
			5'h0D: sig_val = direct_target_velocity;
			5'h0E: sig_val = {16'h0, direct_accel_override};
			5'h0F: sig_val = {16'h0, direct_decel_override};
			5'h10: sig_val = {16'h0, direct_input_mode};
			default: sig_val = 32'h0;
		endcase
	endfunction
	// every update must match the oldest note; a stray one meets an empty note
	always @(posedge mclk) begin
		if (sig_update === 1'b1)
			check({sig_code, sig_val(sig_code)}, exp_q.size() != 0 ? exp_q.pop_front() : 37'h0);
	end

	// ------------------------------
	// tasks
	// ------------------------------
	task check(input logic [36:0] seen, input logic [36:0] expv);
		comparisons++;
		if (seen !== expv) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		do
			@(posedge mclk);
		while (avs_waitrequest !== 1'b0);
		rd_q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check({5'h0, rd_q}, {5'h0, e});
	endtask
	task map(input logic [4:0] k, input logic [15:0] id);
		bus(1'b1, 8'h80 + {1'b0, k, 2'b00}, {16'h0, id});
	endtask
	task tx(input logic [3:0] s, input logic [4:0] c, input logic w32);
		logic [15:0] h;
		logic [15:0] l;
		h = 16'($random(seed));
		l = 16'($random(seed));
		if (w32)
			fb_u.send(s, h, $unsigned($random(seed)) % 3);
		fb_u.send(s + {3'h0, w32}, l, $unsigned($random(seed)) % 3);
		if (c != 5'h00)
			exp_q.push_back({c, w32 ? {h, l} : {16'h0, l}});
	endtask
	task drain;
		while (exp_q.size() != 0)
			@(posedge mclk);
		repeat (4) @(posedge mclk);
	endtask
	task close_out;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		enc2_status_word <= 16'($random(seed));
		enc2_position_value1 <= $random(seed);
		enc2_position_value2 <= $random(seed);
		rdc(`PDM_OFS_CTRL, {29'h0, `PDM_CTRL_RST});
		rdc(8'h88, 32'h0);
		bus(1'b1, 8'h40, 32'h1234);
		rdc(8'h40, 32'h0);
		bus(1'b1, `PDM_OFS_E2_STAT, 32'hFFFF);
		rdc(`PDM_OFS_E2_STAT, 32'h0);
		map(5'd16, 16'hFFFF);
		rdc(8'hC0, 32'hFFFF);
		map(5'd2, `PDM_ID_ENC2_CW);
		tx(4'h1, 5'h00, 1'b0);
		bus(1'b1, `PDM_OFS_ENC_CFG, 32'h0001);
		bus(1'b1, `PDM_OFS_DRV_CFG, 32'h1000);
		@(posedge mclk);
		check({21'h0, encoder_config_word}, 37'h1);
		check({36'h0, enc2_active}, 37'h0);
		rst <= 1'b1;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		check({36'h0, enc2_active}, 37'h1);
		rdc(`PDM_OFS_E2_STAT, {16'h0, enc2_status_word});
		rdc(`PDM_OFS_E2_POS1, enc2_position_value1);
		rdc(`PDM_OFS_E2_POS2, enc2_position_value2);
		for (int i = 0; i < 15; i++) begin
			bus(1'b1, `PDM_OFS_CTRL, {30'h0, 1'b1, POS[i]});
			map(5'd2, IDS[i]);
			map(5'd3, IDS[i]);
			tx(4'h1, 5'(i + 2), W32[i]);
			drain;
		end
		map(5'd2, `PDM_ID_SPEED16);
		tx(4'h1, 5'h00, 1'b0);
		tx(4'h0, 5'h01, 1'b0);
		map(5'd2, `PDM_ID_NONE);
		tx(4'h1, 5'h00, 1'b0);
		tx(4'h0, 5'h01, 1'b0);
		bus(1'b1, `PDM_OFS_CTRL, 32'h0);
		map(5'd3, `PDM_ID_DEVIATION);
		tx(4'h2, 5'h04, 1'b0);
		map(5'd5, `PDM_ID_SPEED16);
		tx(4'h4, 5'h02, 1'b0);
		drain;
		bus(1'b1, `PDM_OFS_CTRL, 32'h2);
		bus(1'b1, `PDM_OFS_TELEGRAM, 32'h1);
		map(5'd2, `PDM_ID_GAIN);
		tx(4'h1, 5'h02, 1'b0);
		bus(1'b1, `PDM_OFS_CTRL, 32'h3);
		bus(1'b1, `PDM_OFS_TELEGRAM, 32'h65);
		tx(4'h1, 5'h09, 1'b0);
		drain;
		bus(1'b1, `PDM_OFS_TELEGRAM, 32'h0);
		// hold the drain, fill the buffer until it refuses, then release
		bus(1'b1, `PDM_OFS_CTRL, 32'h6);
		repeat (8) tx(4'h0, 5'h01, 1'b0);
		@(posedge mclk);
		check({36'h0, rx_ready}, 37'h0);
		bus(1'b1, `PDM_OFS_CTRL, 32'h2);
		drain;
		close_out;
	end
endmodule
